// ---- core/uls_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for the line and modem status block
// Assumes: Register port addresses are word indices chosen for this block
// Notes:   Definitions only
`ifndef ULS_DEFINES_SVH
`define ULS_DEFINES_SVH
`define ULS_ADDR_W          3
`define ULS_OFF_MCTL        3'h4
`define ULS_OFF_LSTAT       3'h5
`define ULS_OFF_MSTAT       3'h6
`define ULS_OFF_IID         3'h2
`define ULS_OFF_LCFG        3'h3
`define ULS_MCTL_DTR        0
`define ULS_MCTL_RTS        1
`define ULS_MCTL_AUX1       2
`define ULS_MCTL_AUX2       3
`define ULS_MCTL_LOOP       4
`define ULS_MCTL_RST        5'h00
`define ULS_LCFG_RST        8'h03
`define ULS_LSTAT_RST       8'h60
`define ULS_IID_RLS         3'h6
`define ULS_IID_THRE        3'h2
`define ULS_IID_RDA         3'h4
`define ULS_IID_MS          3'h0
`define ULS_IID_NONE        3'h1
`define ULS_BAUD_DIV_DEF    16'h0044
`endif

// ---- core/uls_pkg.sv ----
// Purpose: Types shared by the line and modem status block
// Assumes: Nothing beyond the defines header
// Notes:   Carries the line status and modem status fields as packed structs
package uls_pkg;
  typedef struct packed {
    logic fifo_err;
    logic tx_idle;
    logic thr_empty;
    logic brk;
    logic frame_err;
    logic par_err;
    logic overrun;
    logic data_ready;
  } uls_lstat_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
    logic d_dcd;
    logic ri_trail;
    logic d_dsr;
    logic d_cts;
  } uls_mstat_t;

  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frame_err;
  } uls_rxchar_t;

  typedef enum logic [1:0] {
    ULS_RX_IDLE,
    ULS_RX_DATA,
    ULS_RX_PAR,
    ULS_RX_STOP
  } uls_rx_state_t;

  typedef enum logic [1:0] {
    ULS_TX_IDLE,
    ULS_TX_START,
    ULS_TX_BITS,
    ULS_TX_STOP
  } uls_tx_state_t;
endpackage

// ---- core/uls_core.sv ----
// Purpose: Serial line and modem status logic with a small transmitter and receiver
// Assumes: One clock, registers reached over a plain strobe port, read data one cycle later
// Notes:
// Notes on behaviour
// - Control bit 3 drives second aux output low when set, high when clear.
// - A control bit puts the device into local loopback for self test.
// - Control bits 5 to 7 always read zero.
// - Data ready sets when a character lands; clears when rx_take takes it.
// - Overrun sets when a character arrives before the previous one is read.
// - Parity error sets when a received character fails the parity check.
// - Framing error sets when a received character lacks a valid stop bit.
// - Break flags when receive input stays low beyond a full character time.
// - Holding register empty bit set while empty; requests interrupt when enabled.
// - Transmitter idle bit set when holding register is empty and shift register is idle.
// - Overrun, parity, framing or break raise the receiver line status interrupt.
// - Change bits for clear-to-send, data-set-ready, carrier detect latch; clear on read.
// - Ring trailing-edge bit sets when ring indicator goes high to low.
// - Status bits 4 to 7 show inverted clear-to-send, set-ready, ring, carrier inputs.
// - Any of modem status bits 0 to 3 set raises modem status interrupt.
// - Control bit 2 drives first aux output low when set, high when clear.
// - Line status interrupt is top, code 6; modem status lowest, code 0.
`timescale 1ns/10ps
`include "uls_defines.svh"
module uls_core
  import uls_pkg::*;
#(
  parameter logic [15:0] BAUD_DIV = `ULS_BAUD_DIV_DEF
)
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Register port
  input  wire logic [`ULS_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // Transmit and receive data path
  input  wire logic [7:0]             tx_data,
  input  wire logic                   tx_load,
  output logic      [7:0]             rx_data,
  input  wire logic                   rx_take,
  input  wire logic                   thre_int_en,
  // Serial and handshake pins
  input  wire logic                   serial_in,
  output logic                        serial_out,
  input  wire logic                   cts_n,
  input  wire logic                   dsr_n,
  input  wire logic                   ri_n,
  input  wire logic                   dcd_n,
  output logic                        dtr_n,
  output logic                        rts_n,
  output logic                        aux_output_first,
  output logic                        aux_output_second,
  // Interrupt summary
  output logic                        irq,
  output logic      [2:0]             irq_id
);

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic [4:0]  mctl_q;
  logic [7:0]  lcfg_q;
  logic [4:0]  pin_s1_q;
  logic [4:0]  pin_s2_q;
  logic [4:0]  pin_prev_q;
  uls_lstat_t  lstat_q;
  uls_mstat_t  mstat_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rx_data_q;
  logic [15:0] rx_tick_q;
  logic [3:0]  rx_cnt_q;
  logic [7:0]  rx_sh_q;
  logic        rx_par_bad_q;
  logic        rx_prev_q;
  uls_rx_state_t rx_st_q;
  logic [15:0] tx_tick_q;
  logic [3:0]  tx_cnt_q;
  logic [7:0]  tx_hold_q;
  logic [7:0]  tx_sh_q;
  logic        tx_par_q;
  logic        tx_line_q;
  uls_tx_state_t tx_st_q;
  logic [19:0] brk_cnt_q;
  logic        rx_done;
  logic        rx_frame_bad;
  logic        loop;
  logic        rx_line;
  logic        brk_hit;
  logic        rls_pend;
  logic        ms_pend;
  logic        rd_lstat;
  logic        rd_mstat;
  logic [3:0]  data_bits;
  logic [19:0] char_ticks;

  function automatic logic par_calc(input logic [7:0] d, input logic [7:0] cfg);
    logic p;
    p = ^d;
    if (cfg[5])
      p = ~cfg[4];
    else if (!cfg[4])
      p = ~p;
    return p;
  endfunction

  // Reset release
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Pin synchronisers: cts, dsr, ri, dcd, serial in
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      pin_s1_q   <= 5'h1F;
      pin_s2_q   <= 5'h1F;
      pin_prev_q <= 5'h1F;
    end
    else
    begin
      pin_s1_q   <= {serial_in, dcd_n, ri_n, dsr_n, cts_n};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign loop       = mctl_q[`ULS_MCTL_LOOP];
  assign rx_line    = loop ? tx_line_q : pin_s2_q[4];
  assign serial_out = loop ? 1'b1 : (tx_line_q & ~lcfg_q[6]);
  assign data_bits  = 4'(5 + lcfg_q[1:0]);
  assign char_ticks = 20'(BAUD_DIV) * 20'(4'd3 + data_bits + 4'(lcfg_q[3]));
  assign rd_lstat   = reg_rd && reg_addr == `ULS_OFF_LSTAT;
  assign rd_mstat   = reg_rd && reg_addr == `ULS_OFF_MSTAT;

  // Modem control outputs
  assign dtr_n             = ~mctl_q[`ULS_MCTL_DTR];
  assign rts_n             = ~mctl_q[`ULS_MCTL_RTS];
  assign aux_output_first  = ~mctl_q[`ULS_MCTL_AUX1];
  assign aux_output_second = ~mctl_q[`ULS_MCTL_AUX2];

  // Control registers
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      mctl_q <= `ULS_MCTL_RST;
      lcfg_q <= `ULS_LCFG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ULS_OFF_MCTL)
        mctl_q <= reg_wdata[4:0];
      if (reg_addr == `ULS_OFF_LCFG)
        lcfg_q <= reg_wdata;
    end
  end

  // Receiver
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      rx_st_q      <= ULS_RX_IDLE;
      rx_tick_q    <= 16'h0000;
      rx_cnt_q     <= 4'h0;
      rx_sh_q      <= 8'h00;
      rx_par_bad_q <= 1'b0;
      rx_prev_q    <= 1'b1;
    end
    else
    begin
      rx_prev_q <= rx_line;
      rx_tick_q <= (rx_tick_q == 16'h0000) ? BAUD_DIV - 16'h0001 : rx_tick_q - 16'h0001;
      unique case (rx_st_q)
        ULS_RX_IDLE:
          if (!rx_line && rx_prev_q) // Fresh start edge only, a held break gives one character
          begin
            rx_st_q      <= ULS_RX_DATA;
            rx_tick_q    <= BAUD_DIV + (BAUD_DIV >> 1);
            rx_cnt_q     <= 4'h0;
            rx_sh_q      <= 8'h00;
            rx_par_bad_q <= 1'b0;
          end
        ULS_RX_DATA:
          if (rx_tick_q == 16'h0000)
          begin
            rx_sh_q[rx_cnt_q[2:0]] <= rx_line;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q + 4'h1 == data_bits)
              rx_st_q <= lcfg_q[3] ? ULS_RX_PAR : ULS_RX_STOP;
          end
        ULS_RX_PAR:
          if (rx_tick_q == 16'h0000)
          begin
            rx_par_bad_q <= rx_line != par_calc(rx_sh_q, lcfg_q);
            rx_st_q      <= ULS_RX_STOP;
          end
        ULS_RX_STOP:
          if (rx_tick_q == 16'h0000)
            rx_st_q <= ULS_RX_IDLE;
      endcase
    end
  end

  assign rx_done      = rx_st_q == ULS_RX_STOP && rx_tick_q == 16'h0000;
  assign rx_frame_bad = !rx_line;

  // Break detector
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      brk_cnt_q <= 20'h00000;
    else if (rx_line)
      brk_cnt_q <= 20'h00000;
    else if (brk_cnt_q <= char_ticks)
      brk_cnt_q <= brk_cnt_q + 20'h00001;
  end

  assign brk_hit = brk_cnt_q == char_ticks;

  // Transmitter
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      tx_st_q   <= ULS_TX_IDLE;
      tx_tick_q <= 16'h0000;
      tx_cnt_q  <= 4'h0;
      tx_sh_q   <= 8'h00;
      tx_hold_q <= 8'h00;
      tx_par_q  <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else
    begin
      if (tx_load)
        tx_hold_q <= tx_data;
      tx_tick_q <= (tx_tick_q == 16'h0000) ? BAUD_DIV - 16'h0001 : tx_tick_q - 16'h0001;
      unique case (tx_st_q)
        ULS_TX_IDLE:
          if (!lstat_q.thr_empty)
          begin
            tx_st_q   <= ULS_TX_START;
            tx_sh_q   <= tx_hold_q;
            tx_par_q  <= par_calc(tx_hold_q & 8'((9'h100 >> (4'h8 - data_bits)) - 9'h001), lcfg_q);
            tx_tick_q <= BAUD_DIV - 16'h0001;
            tx_line_q <= 1'b0;
            tx_cnt_q  <= 4'h0;
          end
        ULS_TX_START:
          if (tx_tick_q == 16'h0000)
          begin
            tx_st_q   <= ULS_TX_BITS;
            tx_line_q <= tx_sh_q[0];
            tx_sh_q   <= tx_sh_q >> 1;
          end
        ULS_TX_BITS:
          if (tx_tick_q == 16'h0000)
          begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q + 4'h1 < data_bits)
            begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= tx_sh_q >> 1;
            end
            else if (lcfg_q[3] && tx_cnt_q + 4'h1 == data_bits)
              tx_line_q <= tx_par_q;
            else
            begin
              tx_line_q <= 1'b1;
              tx_st_q   <= ULS_TX_STOP;
            end
          end
        ULS_TX_STOP:
          if (tx_tick_q == 16'h0000)
            tx_st_q <= ULS_TX_IDLE;
      endcase
    end
  end

  // Line status: hardware sets win over read clears
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      lstat_q   <= uls_lstat_t'(`ULS_LSTAT_RST);
      rx_data_q <= 8'h00;
    end
    else
    begin
      lstat_q.fifo_err <= 1'b0;
      lstat_q.tx_idle  <= tx_st_q == ULS_TX_IDLE && lstat_q.thr_empty;
      if (tx_load)
        lstat_q.thr_empty <= 1'b0;
      else if (tx_st_q == ULS_TX_IDLE && !lstat_q.thr_empty)
        lstat_q.thr_empty <= 1'b1;
      else if (!lstat_q.thr_empty && !lstat_q.tx_idle)
        lstat_q.thr_empty <= lstat_q.thr_empty;
      if (rd_lstat)
      begin
        lstat_q.overrun   <= 1'b0;
        lstat_q.par_err   <= 1'b0;
        lstat_q.frame_err <= 1'b0;
        lstat_q.brk       <= 1'b0;
      end
      if (rx_take)
        lstat_q.data_ready <= 1'b0;
      if (brk_hit)
        lstat_q.brk <= 1'b1;
      if (rx_done && !brk_hit && brk_cnt_q < char_ticks)
      begin
        rx_data_q          <= rx_sh_q;
        lstat_q.data_ready <= 1'b1;
        if (lstat_q.data_ready && !rx_take)
          lstat_q.overrun <= 1'b1;
        if (rx_par_bad_q)
          lstat_q.par_err <= 1'b1;
        if (rx_frame_bad)
          lstat_q.frame_err <= 1'b1;
      end
    end
  end

  // Modem status: change bits set on synchronised edges, clear on read
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      mstat_q <= '0;
    else
    begin
      mstat_q.cts <= loop ? mctl_q[`ULS_MCTL_RTS]  : ~pin_s2_q[0];
      mstat_q.dsr <= loop ? mctl_q[`ULS_MCTL_DTR]  : ~pin_s2_q[1];
      mstat_q.ri  <= loop ? mctl_q[`ULS_MCTL_AUX1] : ~pin_s2_q[2];
      mstat_q.dcd <= loop ? mctl_q[`ULS_MCTL_AUX2] : ~pin_s2_q[3];
      if (rd_mstat)
        mstat_q[3:0] <= 4'h0;
      if (mstat_q.cts != (loop ? mctl_q[`ULS_MCTL_RTS] : ~pin_s2_q[0]))
        mstat_q.d_cts <= 1'b1;
      if (mstat_q.dsr != (loop ? mctl_q[`ULS_MCTL_DTR] : ~pin_s2_q[1]))
        mstat_q.d_dsr <= 1'b1;
      if (mstat_q.dcd != (loop ? mctl_q[`ULS_MCTL_AUX2] : ~pin_s2_q[3]))
        mstat_q.d_dcd <= 1'b1;
      if (!loop && pin_prev_q[2] && !pin_s2_q[2])
        mstat_q.ri_trail <= 1'b1;
      else if (loop && !mstat_q.ri && mctl_q[`ULS_MCTL_AUX1])
        mstat_q.ri_trail <= 1'b1;
    end
  end

  // Interrupt priority
  assign rls_pend = |lstat_q[4:1];
  assign ms_pend  = |mstat_q[3:0];
  always_comb
  begin
    irq_id = `ULS_IID_NONE;
    if (rls_pend)
      irq_id = `ULS_IID_RLS;
    else if (lstat_q.data_ready)
      irq_id = `ULS_IID_RDA;
    else if (thre_int_en && lstat_q.thr_empty)
      irq_id = `ULS_IID_THRE;
    else if (ms_pend)
      irq_id = `ULS_IID_MS;
  end
  assign irq = irq_id != `ULS_IID_NONE;

  // Read data
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `ULS_OFF_MCTL:  rdata_q <= {3'h0, mctl_q};
        `ULS_OFF_LSTAT: rdata_q <= lstat_q;
        `ULS_OFF_MSTAT: rdata_q <= mstat_q;
        `ULS_OFF_IID:   rdata_q <= {5'h00, irq_id};
        `ULS_OFF_LCFG:  rdata_q <= lcfg_q;
        default:        rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign rx_data   = rx_data_q;

endmodule // uls_core

// ---- bench/uls_core_sva.sv ----
// Purpose: Port checks of the line and modem status block
// Assumes: Read data stand one cycle after the read strobe
// Notes:   Helpers track loopback and quiet time of the handshake inputs
`timescale 1ns/10ps
`include "uls_defines.svh"
module uls_core_sva
  import uls_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic       tx_load,
  input wire logic       serial_out,
  input wire logic       cts_n,
  input wire logic       dsr_n,
  input wire logic       ri_n,
  input wire logic       dcd_n,
  input wire logic       aux_output_first,
  input wire logic       aux_output_second,
  // Interrupt summary
  input wire logic       irq,
  input wire logic [2:0] irq_id
);
  logic       loop_q;
  logic [3:0] hs_q;
  logic [3:0] quiet_q;
  logic       wr_ctl;
  logic       rd_ls;
  logic       rd_ms;
  assign wr_ctl = reg_wr && reg_addr == `ULS_OFF_MCTL;
  assign rd_ls  = reg_rd && reg_addr == `ULS_OFF_LSTAT;
  assign rd_ms  = reg_rd && reg_addr == `ULS_OFF_MSTAT;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Loopback state
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) loop_q <= 1'b0;
    else if (wr_ctl) loop_q <= reg_wdata[`ULS_MCTL_LOOP];
  // Cycles since handshake inputs or control last changed
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      hs_q    <= 4'hF;
      quiet_q <= 4'h0;
    end
    else
    begin
      hs_q <= {dcd_n, ri_n, dsr_n, cts_n};
      if (wr_ctl || hs_q != {dcd_n, ri_n, dsr_n, cts_n}) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
  sequence ls_err_s;
    rd_ls ##1 (reg_rdata[4:1] != 4'h0);
  endsequence
  sequence ms_chg_s;
    rd_ms ##1 (reg_rdata[3:0] != 4'h0);
  endsequence
  sequence ms_twice_s;
    (rd_ms && quiet_q > 4'h5) ##2 rd_ms;
  endsequence
  aux_first_a: assert property (wr_ctl |=> aux_output_first == !$past(reg_wdata[2]))
    else $error("first aux output level wrong");
  aux_second_a: assert property (wr_ctl |=> aux_output_second == !$past(reg_wdata[3]))
    else $error("second aux output level wrong");
  ctl_top_a: assert property (reg_rd && reg_addr == `ULS_OFF_MCTL |=> reg_rdata[7:5] == 3'h0)
    else $error("control top bits not zero");
  ms_level_a: assert property (rd_ms && !loop_q && quiet_q > 4'h5 |=> reg_rdata[7:4] == ~$past(hs_q))
    else $error("modem levels wrong");
  loop_mark_a: assert property (loop_q && $past(loop_q, 2) |-> serial_out)
    else $error("serial output not idle in loopback");
  ls_irq_a: assert property (ls_err_s |-> $past(irq_id) == `ULS_IID_RLS)
    else $error("line status interrupt missing");
  ms_irq_a: assert property (ms_chg_s |-> $past(irq))
    else $error("modem status interrupt missing");
  ms_clear_a: assert property (ms_twice_s |=> reg_rdata[3:0] == 4'h0)
    else $error("modem change bits not cleared");
  tx_busy_a: assert property (tx_load ##2 rd_ls |=> !reg_rdata[6])
    else $error("shifter idle while busy");
endmodule // uls_core_sva

// ---- bench/uls_modem_model.sv ----
// Purpose: Remote modem on the receive line and handshake inputs
// Assumes: One bit lasts DIV clocks; line idles at mark
// Notes:   Driven through its tasks
`timescale 1ns/10ps
module uls_modem_model
#(
  parameter int DIV = 4
)
(
  // Clock
  input wire logic core_clk,
  // Line and handshake
  output logic     serial_in,
  output logic     cts_n,
  output logic     dsr_n,
  output logic     ri_n,
  output logic     dcd_n
);
  initial
  begin
    serial_in = 1'b1;
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
  end
  // Hold the line for n bit times
  task automatic bits(input logic b, input int n);
    @(posedge core_clk);
    serial_in <= b;
    repeat (n * DIV - 1) @(posedge core_clk);
  endtask
  // Frame, LSB first, odd parity on request
  task automatic send(input logic [7:0] d, input logic par, input logic bad, input logic stop);
    bits(1'b0, 1);
    for (int i = 0; i < 8; i++) bits(d[i], 1);
    if (par) bits(~^d ^ bad, 1);
    bits(stop, 1);
    bits(1'b1, 2);
  endtask
  task automatic hs(input logic [3:0] h);
    @(posedge core_clk);
    {dcd_n, ri_n, dsr_n, cts_n} <= h;
  endtask
endmodule // uls_modem_model

// ---- bench/tb.sv ----
// Purpose: Self-checking bench of the line and modem status block
// Assumes: Bit time of four clocks, 8-bit frames
// Notes:   Reads queue their expected value; a monitor compares
`timescale 1ns/10ps
`include "uls_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import uls_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic       tx_load = 1'b0;
  logic       rx_take = 1'b0;
  logic       thre_int_en = 1'b0;
  logic [7:0] reg_rdata, rx_data, e, d, v, ee, mm;
  logic       serial_in, serial_out, cts_n, dsr_n, ri_n, dcd_n;
  logic       dtr_n, rts_n, aux_output_first, aux_output_second, irq;
  logic [2:0] irq_id;
  logic [3:0] p, h;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic       rd_seen = 1'b0;
  int         n_fail = 0;
  int         checked = 0;
  integer     seed = 32'h04BD;
  always #4 core_clk = ~core_clk;
  uls_core #(.BAUD_DIV(16'h0004)) dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_data, .tx_load, .rx_data, .rx_take, .thre_int_en, .serial_in, .serial_out, .cts_n,
    .dsr_n, .ri_n, .dcd_n, .dtr_n, .rts_n, .aux_output_first, .aux_output_second, .irq, .irq_id);
  uls_modem_model #(.DIV(4)) m_u (.core_clk, .serial_in, .cts_n, .dsr_n, .ri_n, .dcd_n);
  // Read data monitor
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk)
    if (rd_seen)
    begin
      ee = exp_q.pop_front();
      mm = msk_q.pop_front();
      `CHK(reg_rdata & mm, ee)
    end
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] k);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask
  task automatic take;
    @(posedge core_clk);
    rx_take <= 1'b1;
    @(posedge core_clk);
    rx_take <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(4);
    rd(`ULS_OFF_MCTL, 8'h00, 8'hFF);
    rd(`ULS_OFF_MSTAT, 8'h00, 8'hF0);
    rd(`ULS_OFF_LSTAT, 8'h00, 8'h1F);
    for (int i = 0; i < 6; i++)
    begin
      v = $random(seed) & 8'hEF;
      wr(`ULS_OFF_MCTL, v);
      @(negedge core_clk);
      `CHK({aux_output_second, aux_output_first, rts_n, dtr_n}, ~v[3:0])
      rd(`ULS_OFF_MCTL, v & 8'h1F, 8'hFF);
    end
    wr(`ULS_OFF_MCTL, 8'h00);
    // Receive, then overrun
    d = $random(seed);
    m_u.send(d, 1'b0, 1'b0, 1'b1);
    rd(`ULS_OFF_LSTAT, 8'h01, 8'h1F);
    `CHK(rx_data, d)
    take;
    rd(`ULS_OFF_LSTAT, 8'h00, 8'h01);
    m_u.send(8'h5A, 1'b0, 1'b0, 1'b1);
    m_u.send(8'hA5, 1'b0, 1'b0, 1'b1);
    rd(`ULS_OFF_LSTAT, 8'h03, 8'h1F);
    rd(`ULS_OFF_LSTAT, 8'h01, 8'h1F);
    take;
    // Parity, framing, break
    for (int i = 0; i < 3; i++)
    begin
      wr(`ULS_OFF_LCFG, i == 0 ? 8'h0B : 8'h03);
      v = $random(seed) | 8'h80;
      if (i < 2)
        m_u.send(v, i == 0, 1'b1, i == 0);
      else
      begin
        m_u.bits(1'b0, 16);
        m_u.bits(1'b1, 2);
      end
      @(negedge core_clk);
      `CHK({irq, irq_id}, {1'b1, `ULS_IID_RLS})
      rd(`ULS_OFF_LSTAT, i == 2 ? 8'h18 : 8'h04 << i, 8'h1E);
      take;
    end
    // Handshake changes
    rd(`ULS_OFF_MSTAT, 8'h00, 8'hF0);
    p = 4'hF;
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      h = (i == 0) ? 4'hB : (i == 1) ? 4'hF : v[3:0];
      m_u.hs(h);
      settle(8);
      e = {~h, h[3] ^ p[3], p[2] & ~h[2], h[1] ^ p[1], h[0] ^ p[0]};
      if (e[3:0] != 4'h0) `CHK({irq, irq_id}, {1'b1, `ULS_IID_MS})
      rd(`ULS_OFF_MSTAT, e, 8'hFF);
      rd(`ULS_OFF_MSTAT, 8'h00, 8'h0F);
      p = h;
    end
    // Loopback transmit
    wr(`ULS_OFF_MCTL, 8'h10);
    d = $random(seed);
    @(posedge core_clk);
    tx_data <= d;
    tx_load <= 1'b1;
    @(posedge core_clk);
    tx_load <= 1'b0;
    rd(`ULS_OFF_LSTAT, 8'h00, 8'h40);
    `CHK(serial_out, 1'b1)
    settle(80);
    rd(`ULS_OFF_LSTAT, 8'h61, 8'h61);
    `CHK(rx_data, d)
    take;
    rd(`ULS_OFF_MSTAT, 8'h00, 8'hF0);
    thre_int_en <= 1'b1;
    settle(2);
    `CHK({irq, irq_id}, {1'b1, `ULS_IID_THRE})
    @(posedge core_clk);
    thre_int_en <= 1'b0;
    wr(`ULS_OFF_MCTL, 8'h00);
    settle(2);
    wrap_up;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    wrap_up;
  end
endmodule // tb
bind uls_core uls_core_sva chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .tx_load, .serial_out, .cts_n, .dsr_n, .ri_n, .dcd_n, .aux_output_first, .aux_output_second, .irq, .irq_id);
